// *** hw/gicf_pkg.sv ***
// constants and types for the gauge i2c flow-control slave
package gicf_pkg;
   localparam int unsigned CLK_MHZ        = 200;
   localparam logic [6:0]  SLAVE_ADDR     = 7'h55;
   // stretch times and bus timeout in microseconds
   localparam int unsigned WAKE_US        = 4000;
   localparam int unsigned INIT_US        = 4000;
   localparam int unsigned RA_UPD_US      = 24000;
   localparam int unsigned BLK_WR_US      = 72000;
   localparam int unsigned RESTORE_US     = 116000;
   localparam int unsigned EOD_RA_US      = 144000;
   localparam int unsigned BUS_TMO_US     = 2000000;
   // times in whole clock cycles, microseconds times CLK_MHZ, no rounding
   localparam int unsigned WAKE_CYC       = WAKE_US * CLK_MHZ;
   localparam int unsigned INIT_CYC       = INIT_US * CLK_MHZ;
   localparam int unsigned RA_UPD_CYC     = RA_UPD_US * CLK_MHZ;
   localparam int unsigned BLK_WR_CYC     = BLK_WR_US * CLK_MHZ;
   localparam int unsigned RESTORE_CYC    = RESTORE_US * CLK_MHZ;
   localparam int unsigned EOD_RA_CYC     = EOD_RA_US * CLK_MHZ;
   localparam int unsigned BUS_TMO_CYC    = BUS_TMO_US * CLK_MHZ;
   localparam int unsigned CNT_W          = 32;
   localparam logic [1:0]  STRETCH_DIS    = 2'h0;
   typedef enum logic [1:0] {
      GICF_SLEEP  = 2'b00,
      GICF_HIBER  = 2'b01,
      GICF_INIT   = 2'b10,
      GICF_NORMAL = 2'b11
   } gicf_mode_t;
   typedef enum logic [2:0] {
      GICF_JOB_NONE    = 3'b000,
      GICF_JOB_RA      = 3'b001,
      GICF_JOB_BLKWR   = 3'b010,
      GICF_JOB_RESTORE = 3'b011,
      GICF_JOB_EODRA   = 3'b100
   } gicf_job_t;
endpackage

// *** hw/gicf_if.sv ***
// interface between protocol engine and stretch timer
`timescale 1ns/1ps
interface gicf_if;
   import gicf_pkg::*;
   logic             load;
   logic [CNT_W-1:0] cycles;
   logic             busy;
   modport engine (output load, output cycles, input busy);
   modport timer  (input load, input cycles, output busy);
endinterface

// *** hw/gicf_timer.sv ***
// down counter that times one clock stretch
`timescale 1ns/1ps
module gicf_timer
   import gicf_pkg::*;
(
   input  wire logic mclk,   // system clock
   input  wire logic rst_n,  // sync reset, low
   input  wire logic ce,     // clock enable
   gicf_if.timer     tif     // load and busy
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;

   always_comb begin
      cnt_next = cnt_reg;
      if (tif.load) begin
         cnt_next = tif.cycles;
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (ce) begin
         cnt_reg <= cnt_next;
      end
   end

   assign tif.busy = (cnt_reg != '0);
endmodule

// *** hw/gicf_slave.sv ***
// gauge i2c slave: address match, ack, clock stretch and bus timeout
// Rules of the document; RULE_01 to RULE_03, RULE_10 and RULE_11 bind the master
// RULE_01 - above 100 kHz the master splits a subcommand into two one-byte writes, 66 us apart.
// RULE_02 - at 100 kHz or below one incremental two-byte write is allowed, then 66 us wait.
// RULE_03 - after an incremental read ends with nack and stop, the bus stays idle 66 us.
// RULE_04 - in sleep and hibernate every transaction start is stretched up to 4 ms for wake-up.
// RULE_05 - in init and normal modes only packets to our own address are stretched.
// RULE_06 - in init mode SCL may be held after start, ack or first data bit, each at most 4 ms.
// RULE_07 - in normal mode a resistance table update stretches 24 ms, a block write 72 ms.
// RULE_08 - in normal mode a restored block write after power loss stretches 116 ms.
// RULE_09 - in normal mode an end-of-discharge table update stretches 144 ms.
// RULE_10 - the master honours every stretch and does not time out during one.
// RULE_11 - the master leaves 66 us bus-free time between packets to the gauge.
// RULE_12 - the slave answers the fixed seven-bit address followed by the read/write bit.
// RULE_13 - a line held low 2 s makes the slave release both lines, and sleep if still held.
`timescale 1ns/1ps
module gicf_slave
   import gicf_pkg::*;
#(
   parameter int unsigned BUS_TMO = BUS_TMO_CYC
)(
   input  wire logic       mclk,        // system clock
   input  wire logic       rst_n,       // sync reset, low
   input  wire logic       ce,          // clock enable
   input  wire logic [1:0] gaugeMode,   // gicf_mode_t
   input  wire logic [2:0] nvmJob,      // gicf_job_t, sampled at address ack
   input  wire logic       sclIn,       // SCL pin level
   input  wire logic       sdaIn,       // SDA pin level
   output logic            sclOe,       // drive SCL low
   output logic            sdaOe,       // drive SDA low
   output logic            addrHit,     // packet is ours
   output logic            stretching,  // SCL held by us
   output logic            busTimeout,  // 2 s low seen
   output logic            sleepReq     // line still held externally
);
   typedef enum logic [2:0] {
      GICF_IDLE  = 3'b000,
      GICF_ADDR  = 3'b001,
      GICF_ACK   = 3'b010,
      GICF_DATA  = 3'b011,
      GICF_DACK  = 3'b100,
      GICF_IGN   = 3'b101
   } gicf_state_t;

   gicf_if tif ();
   gicf_timer u_timer (
      .mclk  (mclk),
      .rst_n (rst_n),
      .ce    (ce),
      .tif   (tif)
   );

   logic [1:0]       sclSync_reg, sdaSync_reg;
   logic             sclDly_reg, sdaDly_reg;
   gicf_state_t      st_reg, st_next;
   logic [2:0]       bit_reg, bit_next;
   logic [7:0]       sh_reg, sh_next;
   logic             byteDone_reg, byteDone_next;
   logic             rw_reg, rw_next;
   logic             hold_reg, hold_next;
   logic             sdaOe_reg, sdaOe_next;
   logic             hit_reg, hit_next;
   logic             tmo_reg, tmo_next;
   logic             slp_reg, slp_next;
   logic [CNT_W-1:0] low_reg, low_next;
   logic             load;
   logic [CNT_W-1:0] loadCyc;

   wire logic scl     = sclSync_reg[1];
   wire logic sda     = sdaSync_reg[1];
   wire logic sclRise = scl & ~sclDly_reg;
   wire logic sclFall = ~scl & sclDly_reg;
   wire logic start   = scl & sclDly_reg & ~sda & sdaDly_reg;
   wire logic stop    = scl & sclDly_reg & sda & ~sdaDly_reg;
   wire logic asleep  = (gaugeMode == GICF_SLEEP) || (gaugeMode == GICF_HIBER);

   function automatic logic [CNT_W-1:0] jobCycles(input logic [2:0] job);
      unique case (job)
         GICF_JOB_RA:      jobCycles = CNT_W'(RA_UPD_CYC);   // RULE_07
         GICF_JOB_BLKWR:   jobCycles = CNT_W'(BLK_WR_CYC);   // RULE_07
         GICF_JOB_RESTORE: jobCycles = CNT_W'(RESTORE_CYC);  // RULE_08
         GICF_JOB_EODRA:   jobCycles = CNT_W'(EOD_RA_CYC);   // RULE_09
         default:          jobCycles = '0;
      endcase
   endfunction

   always_comb begin
      st_next    = st_reg;
      bit_next   = bit_reg;
      sh_next    = sh_reg;
      rw_next    = rw_reg;
      byteDone_next = byteDone_reg;
      hold_next  = hold_reg & tif.busy;
      sdaOe_next = sdaOe_reg;
      hit_next   = hit_reg;
      load       = 1'b0;
      loadCyc    = '0;
      tmo_next   = tmo_reg;
      slp_next   = slp_reg;
      low_next   = (!scl || !sda) ? low_reg + 1'b1 : '0;
      if (start) begin
         st_next  = GICF_ADDR;
         bit_next = 3'h7;
         hit_next = 1'b0;
         byteDone_next = 1'b0;
         if (asleep) begin
            load      = 1'b1;                       // RULE_04
            loadCyc   = CNT_W'(WAKE_CYC);
            hold_next = 1'b1;
         end
      end else if (stop) begin
         st_next    = GICF_IDLE;
         sdaOe_next = 1'b0;
         hit_next   = 1'b0;
      end else if (!hold_reg) begin
         unique case (st_reg)
            GICF_IDLE, GICF_IGN: begin
            end
            GICF_ADDR, GICF_DATA: begin
               if (sclRise) begin
                  sh_next       = {sh_reg[6:0], sda};
                  bit_next      = bit_reg - 3'h1;
                  byteDone_next = (bit_reg == 3'h0);
               end
               if (sclFall && bit_reg == 3'h6 && st_reg == GICF_DATA
                   && gaugeMode == GICF_INIT) begin
                  load      = 1'b1;                   // RULE_06
                  loadCyc   = CNT_W'(INIT_CYC);
                  hold_next = 1'b1;
               end
               // only the fall after the eighth bit ends a byte, not the fall after start
               if (sclFall && byteDone_reg) begin
                  byteDone_next = 1'b0;
                  if (st_reg == GICF_DATA) begin
                     st_next    = GICF_DACK;
                     sdaOe_next = ~rw_reg;
                  end else if (sh_reg[7:1] == SLAVE_ADDR) begin // RULE_12
                     st_next    = GICF_ACK;
                     rw_next    = sh_reg[0];
                     sdaOe_next = 1'b1;
                     hit_next   = 1'b1;
                  end else begin
                     st_next    = GICF_IGN;             // RULE_05
                  end
               end
            end
            GICF_ACK, GICF_DACK: begin
               if (sclFall) begin
                  sdaOe_next = 1'b0;
                  bit_next   = 3'h7;
                  st_next    = rw_reg ? GICF_IGN : GICF_DATA;
                  if (gaugeMode == GICF_NORMAL && st_reg == GICF_ACK
                      && nvmJob != GICF_JOB_NONE) begin
                     load      = 1'b1;                // RULE_05
                     loadCyc   = jobCycles(nvmJob);
                     hold_next = 1'b1;
                  end else if (gaugeMode == GICF_INIT) begin
                     load      = 1'b1;                // RULE_06
                     loadCyc   = CNT_W'(INIT_CYC);
                     hold_next = 1'b1;
                  end
               end
            end
            default: st_next = GICF_IDLE;
         endcase
      end
      // bus held low too long: let go of both lines
      // both lines high again: timeout and sleep request end
      if (scl && sda) begin
         tmo_next = 1'b0;
         slp_next = 1'b0;
      end else if (low_reg >= CNT_W'(BUS_TMO)) begin
         tmo_next   = 1'b1;                           // RULE_13
         hold_next  = 1'b0;
         sdaOe_next = 1'b0;
         st_next    = GICF_IDLE;
         slp_next   = tmo_reg;                        // RULE_13
         low_next   = low_reg;
      end
   end

   assign tif.load   = load;
   assign tif.cycles = loadCyc;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sclSync_reg <= 2'h3;
         sdaSync_reg <= 2'h3;
         sclDly_reg  <= 1'b1;
         sdaDly_reg  <= 1'b1;
         st_reg      <= GICF_IDLE;
         bit_reg     <= 3'h7;
         sh_reg      <= 8'h00;
         byteDone_reg <= 1'b0;
         rw_reg      <= 1'b0;
         hold_reg    <= 1'b0;
         sdaOe_reg   <= 1'b0;
         hit_reg     <= 1'b0;
         tmo_reg     <= 1'b0;
         slp_reg     <= 1'b0;
         low_reg     <= '0;
      end else if (ce) begin
         sclSync_reg <= {sclSync_reg[0], sclIn};
         sdaSync_reg <= {sdaSync_reg[0], sdaIn};
         sclDly_reg  <= scl;
         sdaDly_reg  <= sda;
         st_reg      <= st_next;
         bit_reg     <= bit_next;
         sh_reg      <= sh_next;
         byteDone_reg <= byteDone_next;
         rw_reg      <= rw_next;
         hold_reg    <= hold_next;
         sdaOe_reg   <= sdaOe_next;
         hit_reg     <= hit_next;
         tmo_reg     <= tmo_next;
         slp_reg     <= slp_next;
         low_reg     <= low_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sclOe      <= 1'b0;
         sdaOe      <= 1'b0;
         addrHit    <= 1'b0;
         stretching <= 1'b0;
         busTimeout <= 1'b0;
         sleepReq   <= 1'b0;
      end else if (ce) begin
         sclOe      <= hold_next;
         sdaOe      <= sdaOe_next;
         addrHit    <= hit_next;
         stretching <= hold_next;
         busTimeout <= tmo_next;
         sleepReq   <= slp_next;
      end
   end
endmodule

// *** dv/gicf_master.sv ***
// behavioural i2c master for the gauge slave
`timescale 1ns/1ps
module gicf_master
   import gicf_pkg::*;
(
   input  wire logic mclk,   // system clock
   input  wire logic scl,    // resolved SCL
   input  wire logic sda,    // resolved SDA
   output logic      sclLow, // pull SCL low
   output logic      sdaLow  // pull SDA low
);
   localparam int QTR = 4;      // quarter of the 80 ns SCL period
   localparam int GAP = 13200;  // 66 us bus-free time
   initial begin
      sclLow = 1'b0;
      sdaLow = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // wait while the slave stretches
   task automatic sclHigh();
      int n;
      n = 0;
      sclLow = 1'b0;
      tick(1);
      while (scl !== 1'b1 && n <= int'(EOD_RA_CYC)) begin
         tick(1);
         n++;
      end
      tick(QTR - 1);
   endtask
   task automatic idle();
      sclLow = 1'b0;
      tick(1);
      sdaLow = 1'b0;
   endtask
   task automatic start();
      sdaLow = 1'b0;
      sclHigh();
      sdaLow = 1'b1;
      tick(QTR);
      sclLow = 1'b1;
      tick(QTR);
   endtask
   task automatic sendByte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= -1; i--) begin
         sdaLow = (i >= 0) ? ~b[i] : 1'b0;
         tick(QTR);
         sclHigh();
         if (i < 0) ack = ~sda;
         tick(QTR);
         sclLow = 1'b1;
         tick(QTR);
      end
   endtask
   task automatic stop();
      sdaLow = 1'b1;
      tick(QTR);
      sclHigh();
      sdaLow = 1'b0;
      tick(GAP);
   endtask
endmodule

// *** dv/gicf_slave_asserts.sv ***
// assertions on the gauge i2c slave ports
`timescale 1ns/1ps
module gicf_slave_asserts
   import gicf_pkg::*;
#(
   parameter int unsigned BUS_TMO = BUS_TMO_CYC
)(
   input wire logic       mclk,       // system clock
   input wire logic       rst_n,      // sync reset, low
   input wire logic       ce,         // clock enable
   input wire logic [1:0] gaugeMode,  // gauge mode
   input wire logic [2:0] nvmJob,     // pending memory job
   input wire logic       sclIn,      // SCL pin level
   input wire logic       sdaIn,      // SDA pin level
   input wire logic       sclOe,      // slave pulls SCL
   input wire logic       sdaOe,      // slave pulls SDA
   input wire logic       addrHit,    // packet is ours
   input wire logic       stretching, // SCL held by slave
   input wire logic       busTimeout, // long low seen
   input wire logic       sleepReq    // line still held
);
   logic [31:0] holdCnt;
   logic [31:0] lowCnt;
   always_ff @(posedge mclk) begin
      holdCnt <= (!rst_n || !sclOe) ? 32'h0 : holdCnt + 32'h1;
      lowCnt  <= (!rst_n || (sclIn && sdaIn)) ? 32'h0 : lowCnt + 32'h1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence wakeStart;
      !gaugeMode[1] && sclIn && $fell(sdaIn);
   endsequence
   wake_stretch_a: assert property (wakeStart |-> ##[1:12] sclOe)
      else $error("no wake stretch after start");
   wake_len_a: assert property (!gaugeMode[1] && sclOe |-> holdCnt <= WAKE_CYC)
      else $error("wake stretch too long");
   init_len_a: assert property (gaugeMode == GICF_INIT && sclOe |-> holdCnt <= INIT_CYC)
      else $error("init stretch too long");
   own_only_a: assert property (gaugeMode[1] && $rose(sclOe) |-> addrHit)
      else $error("stretch on foreign packet");
   job_needed_a: assert property (gaugeMode == GICF_NORMAL && $rose(sclOe) |-> nvmJob != GICF_JOB_NONE)
      else $error("normal stretch without job");
   restore_len_a: assert property (nvmJob == GICF_JOB_RESTORE && sclOe |-> holdCnt <= RESTORE_CYC)
      else $error("restore stretch too long");
   normal_len_a: assert property (gaugeMode == GICF_NORMAL && sclOe |-> holdCnt <= EOD_RA_CYC)
      else $error("normal stretch too long");
   ack_own_a: assert property ($rose(sdaOe) |-> ##[0:2] addrHit)
      else $error("ack without address match");
   tmo_late_a: assert property ($rose(busTimeout) |-> lowCnt >= BUS_TMO)
      else $error("bus timeout too early");
   tmo_release_a: assert property (busTimeout ##1 busTimeout |-> !sclOe && !sdaOe)
      else $error("lines held after timeout");
endmodule

// *** dv/gicf_slave_test.sv ***
// testbench for the gauge i2c slave
`timescale 1ns/1ps
module gicf_slave_test;
   import gicf_pkg::*;
   localparam int unsigned BUS_TMO = 2000;
   logic       mclk, rstN, ce, sclOe, sdaOe, addrHit, stretching, busTimeout, sleepReq;
   logic       mSclLow, mSdaLow, ack;
   logic [1:0] gaugeMode;
   logic [2:0] nvmJob;
   wire        scl = ~(mSclLow | sclOe);
   wire        sda = ~(mSdaLow | sdaOe);
   int         fails = 0;
   int         compares = 0;
   gicf_slave #(.BUS_TMO(BUS_TMO)) i_gicf_slave (.mclk(mclk), .rst_n(rstN), .ce(ce),
      .gaugeMode(gaugeMode), .nvmJob(nvmJob), .sclIn(scl), .sdaIn(sda), .sclOe(sclOe),
      .sdaOe(sdaOe), .addrHit(addrHit), .stretching(stretching), .busTimeout(busTimeout),
      .sleepReq(sleepReq));
   gicf_master i_gicf_master (.mclk(mclk), .scl(scl), .sda(sda), .sclLow(mSclLow),
      .sdaLow(mSdaLow));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic report_and_stop();
      if (fails == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic doReset(input logic [1:0] m, input logic [2:0] j);
      rstN = 1'b0;
      ce = 1'b1;
      gaugeMode = m;
      nvmJob = j;
      i_gicf_master.idle();
      repeat (2) @(posedge mclk);
      #1 rstN = 1'b1;
      i_gicf_master.tick(3);
   endtask
   task automatic ownWrite();
      i_gicf_master.start();
      i_gicf_master.sendByte(8'hAA, ack);
      check({ack, addrHit}, 2'b11);
      i_gicf_master.sendByte(8'h00, ack);
      check({ack, sclOe}, 2'b10);
      i_gicf_master.stop();
      check(addrHit, 1'b0);
      i_gicf_master.start();
      i_gicf_master.sendByte(8'hAB, ack);
      check(ack, 1'b1);
      i_gicf_master.stop();
   endtask
   // foreign packet with a job pending must pass untouched
   task automatic foreignPkt();
      doReset(GICF_NORMAL, GICF_JOB_BLKWR);
      i_gicf_master.start();
      i_gicf_master.sendByte(8'hA8, ack);
      check({ack, addrHit, sclOe}, 3'b000);
      i_gicf_master.sendByte(8'h00, ack);
      check(sclOe, 1'b0);
      i_gicf_master.stop();
   endtask
   task automatic wakeStretch(input logic [1:0] m);
      doReset(m, GICF_JOB_NONE);
      i_gicf_master.start();
      i_gicf_master.tick(12);
      check(sclOe, 1'b1);
      i_gicf_master.tick(100);
      check(stretching, 1'b1);
   endtask
   task automatic initStretch();
      doReset(GICF_INIT, GICF_JOB_NONE);
      i_gicf_master.start();
      i_gicf_master.sendByte(8'hAA, ack);
      check({ack, sclOe}, 2'b11);
   endtask
   task automatic jobStretch();
      for (int j = 1; j <= 4; j++) begin
         doReset(GICF_NORMAL, 3'(j));
         i_gicf_master.start();
         i_gicf_master.sendByte(8'hAA, ack);
         check(sclOe, 1'b1);
      end
   endtask
   task automatic busHeld();
      doReset(GICF_NORMAL, GICF_JOB_NONE);
      // disabled slave must not count a long low
      ce = 1'b0;
      i_gicf_master.sdaLow = 1'b1;
      i_gicf_master.tick(BUS_TMO + 20);
      check(busTimeout, 1'b0);
      ce = 1'b1;
      i_gicf_master.tick(BUS_TMO - 10);
      check(busTimeout, 1'b0);
      i_gicf_master.tick(40);
      check({busTimeout, sleepReq, sclOe, sdaOe}, 4'b1100);
      i_gicf_master.sdaLow = 1'b0;
      i_gicf_master.tick(10);
      check(busTimeout, 1'b0);
   endtask
   initial begin
      doReset(GICF_NORMAL, GICF_JOB_NONE);
      ownWrite();
      foreignPkt();
      wakeStretch(GICF_SLEEP);
      wakeStretch(GICF_HIBER);
      initStretch();
      jobStretch();
      busHeld();
      report_and_stop();
   end
   initial begin
      repeat (100000) @(posedge mclk);
      fails++;
      report_and_stop();
   end
endmodule
bind gicf_slave gicf_slave_asserts #(.BUS_TMO(BUS_TMO)) i_gicf_slave_asserts (.mclk(mclk),
   .rst_n(rst_n), .ce(ce), .gaugeMode(gaugeMode), .nvmJob(nvmJob), .sclIn(sclIn),
   .sdaIn(sdaIn), .sclOe(sclOe), .sdaOe(sdaOe), .addrHit(addrHit), .stretching(stretching),
   .busTimeout(busTimeout), .sleepReq(sleepReq));
